/* csr_pkg.sv */
package csr_pkg;

    // Register offsets in the byte-wide special register space.
    localparam logic [7:0] CSR_STACK_POINTER_ADDR = 8'h81;
    localparam logic [7:0] CSR_POINTER_LOW_BYTE_ADDR = 8'h82;
    localparam logic [7:0] CSR_POINTER_HIGH_BYTE_ADDR = 8'h83;
    localparam logic [7:0] CSR_CODE_BANK_SELECT_ADDR = 8'ha1;
    localparam logic [7:0] CSR_POINTER_SELECT_CONTROL_ADDR = 8'ha2;
    localparam logic [7:0] CSR_CODE_MAP_CONTROL_ADDR = 8'hc0;
    localparam logic [7:0] CSR_PROGRAM_STATUS_FLAGS_ADDR = 8'hd0;
    localparam logic [7:0] CSR_ARITH_PRIMARY_ADDR = 8'he0;
    localparam logic [7:0] CSR_ARITH_SECONDARY_ADDR = 8'hf0;

    // Reset values.
    localparam logic [7:0] CSR_STACK_POINTER_RST = 8'h07;
    localparam logic [7:0] CSR_BYTE_RST = 8'h00;
    localparam logic [15:0] CSR_POINTER_RST = 16'h0000;
    localparam logic CSR_UPPER_ROM_RST = 1'b1;

    // Field positions.
    localparam int CSR_ISP_BIT = 2;
    localparam int CSR_ROM_SEL_BIT = 1;
    localparam int CSR_CARRY_BIT = 7;
    localparam int CSR_AUX_CARRY_BIT = 6;
    localparam int CSR_WORK_BANK_LO = 3;
    localparam int CSR_RANGE_BIT = 2;
    localparam int CSR_PARITY_BIT = 0;

    // Strap value that marks in-system programming.
    localparam logic [1:0] CSR_ISP_STRAP = 2'h3;

    // Code window and stack region.
    localparam logic [15:0] CSR_UPPER_WINDOW_BASE = 16'hfc00;
    localparam logic [7:0] CSR_STACK_LOW = 8'h08;
    localparam logic [7:0] CSR_STACK_HIGH = 8'h7f;
    localparam int CSR_STACK_WORDS = 128;

    // Byte-wide register access from the execution logic.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csr_byte_req_s;

    // Single-bit access by bit address.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic wdata;
    } csr_bit_req_s;

    // Flag update from the arithmetic unit.
    typedef struct packed {
        logic upd;
        logic carry;
        logic aux_carry;
        logic range;
    } csr_flag_upd_s;

endpackage : csr_pkg

/* csr_core_special_registers.sv */
`timescale 1ns/100ps
`default_nettype none

module csr_core_special_registers (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [1:0] i_mode_strap_pins,
    input wire csr_pkg::csr_byte_req_s i_byte_req,
    output logic [7:0] o_byte_rdata,
    input wire csr_pkg::csr_bit_req_s i_bit_req,
    output logic o_bit_rdata,
    input wire logic i_mul,
    input wire logic i_div,
    input wire logic i_accum_wr,
    input wire logic [7:0] i_accum_wdata,
    input wire csr_pkg::csr_flag_upd_s i_flag_upd,
    input wire logic i_push,
    input wire logic [7:0] i_push_data,
    input wire logic i_pop,
    output logic [7:0] o_pop_data,
    input wire logic i_ptr_wr,
    input wire logic [15:0] i_ptr_wdata,
    input wire logic i_ptr_inc,
    output logic [15:0] o_data_pointer,
    input wire logic [15:0] i_code_addr,
    output logic o_code_from_rom,
    output logic o_code_bank,
    output logic [1:0] o_work_bank_select,
    output logic o_insystem_prog_indicator
);
    import csr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] stack_ptr_q;
    logic [7:0] accum_q;
    logic [7:0] sec_q;
    logic [7:1] status_q;
    logic upper_code_rom_select_q;
    logic code_bank_q;
    logic pointer_copy_select_q;
    logic insystem_prog_indicator_q;
    logic [15:0] dp_q [2];
    logic [7:0] stack_mem [CSR_STACK_WORDS];
    logic [7:0] pop_data_q;
    logic [7:0] byte_rdata_q;
    logic bit_rdata_q;
    logic parity;
    logic [15:0] product;
    logic [7:0] quotient;
    logic [7:0] remainder;
    logic div_ok;
    logic [7:0] stack_ptr_inc;

    // Byte write or bit write that lands on the register at reg_addr.
    // Bit addresses only ever reach offsets that are multiples of eight.
    function automatic logic [7:0] apply_wr(input logic [7:0] cur, input logic [7:0] reg_addr,
                                            input csr_byte_req_s br, input csr_bit_req_s bt);
        logic [7:0] v;
        v = cur;
        if (br.wr && br.addr == reg_addr) begin
            v = br.wdata;
        end else if (bt.wr && {bt.addr[7:3], 3'h0} == reg_addr) begin
            v[bt.addr[2:0]] = bt.wdata;
        end
        return v;
    endfunction : apply_wr

    function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] stk_ptr, input logic [7:0] accum,
                                             input logic [7:0] sec, input logic [7:0] status, input logic [15:0] dp,
                                             input logic [7:0] code_map, input logic bank, input logic sel);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            CSR_STACK_POINTER_ADDR: v = stk_ptr;
            CSR_POINTER_LOW_BYTE_ADDR: v = dp[7:0];
            CSR_POINTER_HIGH_BYTE_ADDR: v = dp[15:8];
            CSR_CODE_BANK_SELECT_ADDR: v = {7'h00, bank};
            CSR_POINTER_SELECT_CONTROL_ADDR: v = {7'h00, sel};
            CSR_CODE_MAP_CONTROL_ADDR: v = code_map;
            CSR_PROGRAM_STATUS_FLAGS_ADDR: v = status;
            CSR_ARITH_PRIMARY_ADDR: v = accum;
            CSR_ARITH_SECONDARY_ADDR: v = sec;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////////////////
    assign parity = ^accum_q;
    assign product = accum_q * sec_q;
    assign div_ok = (accum_q != 8'h00);
    // A zero divisor would give a meaningless quotient, so the result is replaced: quotient 0xff, remainder the dividend.
    assign quotient = div_ok ? sec_q / accum_q : 8'hff;
    assign remainder = div_ok ? sec_q % accum_q : sec_q;
    assign stack_ptr_inc = stack_ptr_q + 8'h01;

    logic [7:0] code_map_view;
    logic [7:0] status_view;
    logic [7:0] bit_byte;
    assign code_map_view = {5'h00, insystem_prog_indicator_q, upper_code_rom_select_q, 1'b0};
    assign status_view = {status_q, parity};
    // Bit reads pick one bit out of the byte view of the register that holds it.
    assign bit_byte = read_byte({i_bit_req.addr[7:3], 3'h0}, stack_ptr_q, accum_q, sec_q, status_view,
                                o_data_pointer, code_map_view, code_bank_q, pointer_copy_select_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Strap pins are sampled, never caught under the asynchronous reset.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            insystem_prog_indicator_q <= 1'b0;
        end else begin
            insystem_prog_indicator_q <= (i_mode_strap_pins == CSR_ISP_STRAP);
        end
    end

    logic [7:0] code_map_next;
    assign code_map_next = apply_wr(code_map_view, CSR_CODE_MAP_CONTROL_ADDR, i_byte_req, i_bit_req);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            upper_code_rom_select_q <= CSR_UPPER_ROM_RST;
        end else begin
            upper_code_rom_select_q <= code_map_next[CSR_ROM_SEL_BIT];
        end
    end

    logic [7:0] bank_next;
    assign bank_next = apply_wr({7'h00, code_bank_q}, CSR_CODE_BANK_SELECT_ADDR, i_byte_req, i_bit_req);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            code_bank_q <= 1'b0;
        end else begin
            code_bank_q <= bank_next[0];
        end
    end

    logic [7:0] sel_next;
    assign sel_next = apply_wr({7'h00, pointer_copy_select_q}, CSR_POINTER_SELECT_CONTROL_ADDR,
                               i_byte_req, i_bit_req);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pointer_copy_select_q <= 1'b0;
        end else begin
            pointer_copy_select_q <= sel_next[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Multiply and divide take priority over a register write in the same cycle.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            accum_q <= CSR_BYTE_RST;
        end else if (i_mul) begin
            accum_q <= product[7:0];
        end else if (i_div) begin
            accum_q <= quotient;
        end else if (i_accum_wr) begin
            accum_q <= i_accum_wdata;
        end else begin
            accum_q <= apply_wr(accum_q, CSR_ARITH_PRIMARY_ADDR, i_byte_req, i_bit_req);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sec_q <= CSR_BYTE_RST;
        end else if (i_mul) begin
            sec_q <= product[15:8];
        end else if (i_div) begin
            sec_q <= remainder;
        end else begin
            sec_q <= apply_wr(sec_q, CSR_ARITH_SECONDARY_ADDR, i_byte_req, i_bit_req);
        end
    end

    logic [7:0] status_next;
    assign status_next = apply_wr(status_view, CSR_PROGRAM_STATUS_FLAGS_ADDR, i_byte_req, i_bit_req);

    // The parity bit is not stored; writes to it are dropped.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_q <= CSR_BYTE_RST[7:1];
        end else begin
            status_q <= status_next[7:1];
            if (i_mul || i_div) begin
                status_q[CSR_CARRY_BIT] <= 1'b0;
                status_q[CSR_RANGE_BIT] <= i_mul ? (product[15:8] != 8'h00) : !div_ok;
            end else if (i_flag_upd.upd) begin
                status_q[CSR_CARRY_BIT] <= i_flag_upd.carry;
                status_q[CSR_AUX_CARRY_BIT] <= i_flag_upd.aux_carry;
                status_q[CSR_RANGE_BIT] <= i_flag_upd.range;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A push and a pop in one cycle are not expected; push is then served alone.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stack_ptr_q <= CSR_STACK_POINTER_RST;
        end else if (i_push) begin
            stack_ptr_q <= stack_ptr_inc;
        end else if (i_pop) begin
            stack_ptr_q <= stack_ptr_q - 8'h01;
        end else begin
            stack_ptr_q <= apply_wr(stack_ptr_q, CSR_STACK_POINTER_ADDR, i_byte_req, i_bit_req);
        end
    end

    // Only the low seven address bits index memory, so the stack wraps within 0x00-0x7F.
    always_ff @(posedge i_clk) begin
        if (i_push) begin
            stack_mem[stack_ptr_inc[6:0]] <= i_push_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pop_data_q <= CSR_BYTE_RST;
        end else if (i_pop && !i_push) begin
            pop_data_q <= stack_mem[stack_ptr_q[6:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    for (genvar gi = 0; gi < 2; gi++) begin : g_ptr_copy
        logic hit;
        logic [7:0] lo_next;
        logic [7:0] hi_next;
        assign hit = (pointer_copy_select_q == 1'(gi));
        assign lo_next = apply_wr(dp_q[gi][7:0], CSR_POINTER_LOW_BYTE_ADDR, i_byte_req, i_bit_req);
        assign hi_next = apply_wr(dp_q[gi][15:8], CSR_POINTER_HIGH_BYTE_ADDR, i_byte_req, i_bit_req);
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                dp_q[gi] <= CSR_POINTER_RST;
            end else if (hit) begin
                if (i_ptr_wr) begin
                    dp_q[gi] <= i_ptr_wdata;
                end else if (i_ptr_inc) begin
                    dp_q[gi] <= dp_q[gi] + 16'h0001;
                end else begin
                    dp_q[gi] <= {hi_next, lo_next};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data is registered: it appears the cycle after the read request.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            byte_rdata_q <= CSR_BYTE_RST;
            bit_rdata_q <= 1'b0;
        end else begin
            if (i_byte_req.rd) begin
                byte_rdata_q <= read_byte(i_byte_req.addr, stack_ptr_q, accum_q, sec_q, status_view,
                                          o_data_pointer, code_map_view, code_bank_q,
                                          pointer_copy_select_q);
            end
            if (i_bit_req.rd) begin
                bit_rdata_q <= bit_byte[i_bit_req.addr[2:0]];
            end
        end
    end

    assign o_byte_rdata = byte_rdata_q;
    assign o_bit_rdata = bit_rdata_q;
    assign o_pop_data = pop_data_q;
    assign o_data_pointer = dp_q[pointer_copy_select_q];
    assign o_code_from_rom = upper_code_rom_select_q && (i_code_addr >= CSR_UPPER_WINDOW_BASE);
    assign o_code_bank = code_bank_q;
    assign o_work_bank_select = status_q[CSR_WORK_BANK_LO +: 2];
    assign o_insystem_prog_indicator = insystem_prog_indicator_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    isp_follow_strap_a: assert property ((i_mode_strap_pins == CSR_ISP_STRAP) |=> o_insystem_prog_indicator)
        else $error("indicator not set by strap 3");
    rom_window_map_a: assert property (o_code_from_rom == (upper_code_rom_select_q && i_code_addr[15:10] == 6'h3f))
        else $error("upper window mapping wrong");
    mul_product_split_a: assert property (i_mul |=> {sec_q, accum_q} == $past(accum_q) * $past(sec_q))
        else $error("multiply result misplaced");
    div_result_split_a: assert property ((i_div && !i_mul && accum_q != 8'h00) |=>
        accum_q == $past(sec_q) / $past(accum_q) && sec_q == $past(sec_q) % $past(accum_q))
        else $error("divide result misplaced");
    sec_write_hold_a: assert property ((i_byte_req.wr && i_byte_req.addr == CSR_ARITH_SECONDARY_ADDR)
        && !i_mul && !i_div |=> sec_q == $past(i_byte_req.wdata))
        else $error("secondary write lost");
    parity_track_a: assert property ((i_bit_req.rd && i_bit_req.addr == CSR_PROGRAM_STATUS_FLAGS_ADDR)
        |=> o_bit_rdata == ^$past(accum_q))
        else $error("parity flag wrong");
    // A push, one quiet cycle and a pop must hand the pushed byte straight back.
    push_store_a: assert property ((i_push ##1 (!i_push && !i_pop) ##1 (i_pop && !i_push))
        |=> o_pop_data == $past(i_push_data, 3))
        else $error("pushed byte not returned");
    pop_dec_a: assert property ((i_pop && !i_push) |=> stack_ptr_q == $past(stack_ptr_q) - 8'h01)
        else $error("stack pointer not decremented");
    push_inc_a: assert property (i_push |=> stack_ptr_q == $past(stack_ptr_q) + 8'h01)
        else $error("stack pointer not incremented");
    ptr_other_hold_a: assert property ((pointer_copy_select_q == $past(pointer_copy_select_q))
        |-> dp_q[!pointer_copy_select_q] == $past(dp_q[!pointer_copy_select_q]))
        else $error("unselected pointer copy changed");
    ptr_whole_write_a: assert property (i_ptr_wr |=>
        dp_q[$past(pointer_copy_select_q)] == $past(i_ptr_wdata))
        else $error("pointer write lost");
    reserved_zero_a: assert property (i_byte_req.rd && i_byte_req.addr == CSR_CODE_MAP_CONTROL_ADDR
        |=> o_byte_rdata[7:3] == 5'h00 && o_byte_rdata[0] == 1'b0)
        else $error("reserved bits not zero");

endmodule : csr_core_special_registers
`default_nettype wire

/* csr_exec_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Stands in for the execution logic. A request rises just after an edge, is held over one
// sampling edge and then dropped, so issue leaves one idle cycle between requests.
// Released data lines carry a pattern that changes on every request, never stale values.
module csr_exec_model (
    input wire logic i_clk,
    output csr_pkg::csr_byte_req_s o_byte_req,
    output csr_pkg::csr_bit_req_s o_bit_req,
    output logic o_mul,
    output logic o_div,
    output logic o_accum_wr,
    output logic [7:0] o_accum_wdata,
    output csr_pkg::csr_flag_upd_s o_flag_upd,
    output logic o_push,
    output logic [7:0] o_push_data,
    output logic o_pop,
    output logic o_ptr_wr,
    output logic [15:0] o_ptr_wdata,
    output logic o_ptr_inc
);
    import csr_pkg::*;
    logic [15:0] junk = 16'h0000;
    task automatic idle();
        junk = junk + 16'h3b71;
        o_byte_req = {2'b00, junk};
        o_bit_req = {2'b00, junk[8:0]};
        o_mul = 1'b0;
        o_div = 1'b0;
        o_accum_wr = 1'b0;
        o_accum_wdata = junk[15:8];
        o_flag_upd = {1'b0, junk[2:0]};
        o_push = 1'b0;
        o_push_data = junk[7:0];
        o_pop = 1'b0;
        o_ptr_wr = 1'b0;
        o_ptr_wdata = ~junk;
        o_ptr_inc = 1'b0;
    endtask : idle
    ////////////////////////////////////////
    task automatic op(input logic [3:0] k, input logic [7:0] ad, input logic [15:0] d);
        @(posedge i_clk);
        #1;
        o_accum_wdata = d[7:0];
        o_push_data = d[7:0];
        o_ptr_wdata = d;
        case (k)
            4'h0: o_byte_req = '{1'b1, 1'b0, ad, d[7:0]};
            4'h1: o_byte_req = '{1'b0, 1'b1, ad, 8'h00};
            4'h2: o_bit_req = '{1'b1, 1'b0, ad, d[0]};
            4'h3: o_bit_req = '{1'b0, 1'b1, ad, 1'b0};
            4'h4: o_accum_wr = 1'b1;
            4'h5: o_mul = 1'b1;
            4'h6: o_div = 1'b1;
            4'h7: o_flag_upd = '{1'b1, d[2], d[1], d[0]};
            4'h8: o_push = 1'b1;
            4'h9: o_pop = 1'b1;
            4'ha: o_ptr_wr = 1'b1;
            default: o_ptr_inc = 1'b1;
        endcase
        @(posedge i_clk);
        #1;
        idle();
    endtask : op
    initial idle();
endmodule : csr_exec_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import csr_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [1:0] strap = 2'h0;
    logic [15:0] code_addr = 16'h0000;
    csr_byte_req_s byte_req;
    csr_bit_req_s bit_req;
    csr_flag_upd_s flag_upd;
    logic mul, div, accum_wr, push, pop, ptr_wr, ptr_inc, bit_rdata, rom, bank, isp;
    logic [7:0] accum_wdata, push_data, byte_rdata, pop_data, a, y;
    logic [15:0] ptr_wdata, ptr_val, prod;
    logic [1:0] work_bank;
    logic [7:0] exp_q [$];
    logic [7:0] stk [3];
    logic [2:0] kind = 3'h0;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] ra [10] = '{8'h81, 8'h82, 8'h83, 8'ha1, 8'ha2, 8'hc0, 8'hd0, 8'he0, 8'hf0, 8'h84};
    logic [7:0] rv [10] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    always #20 i_clk = ~i_clk;
    csr_core_special_registers i_csr_core_special_registers (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_mode_strap_pins(strap), .i_byte_req(byte_req), .o_byte_rdata(byte_rdata), .i_bit_req(bit_req),
        .o_bit_rdata(bit_rdata), .i_mul(mul), .i_div(div), .i_accum_wr(accum_wr), .i_accum_wdata(accum_wdata),
        .i_flag_upd(flag_upd), .i_push(push), .i_push_data(push_data), .i_pop(pop), .o_pop_data(pop_data),
        .i_ptr_wr(ptr_wr), .i_ptr_wdata(ptr_wdata), .i_ptr_inc(ptr_inc), .o_data_pointer(ptr_val),
        .i_code_addr(code_addr), .o_code_from_rom(rom), .o_code_bank(bank), .o_work_bank_select(work_bank),
        .o_insystem_prog_indicator(isp));
    csr_exec_model i_csr_exec_model (.i_clk(i_clk), .o_byte_req(byte_req), .o_bit_req(bit_req),
        .o_mul(mul), .o_div(div), .o_accum_wr(accum_wr), .o_accum_wdata(accum_wdata), .o_flag_upd(flag_upd),
        .o_push(push), .o_push_data(push_data), .o_pop(pop), .o_ptr_wr(ptr_wr),
        .o_ptr_wdata(ptr_wdata), .o_ptr_inc(ptr_inc));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic [3:0] k, input logic [7:0] ad, input logic [15:0] d);
        i_csr_exec_model.op(k, ad, d);
    endtask : op
    // Reads of all three kinds note their expectation; the monitor matches it a cycle later.
    task automatic rd(input logic [3:0] k, input logic [7:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        op(k, ad, 16'h0000);
    endtask : rd
    task automatic results();
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    always @(posedge i_clk) begin
        kind <= {byte_req.rd, bit_req.rd, pop};
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    always @(negedge i_clk) begin
        if (kind[2]) chk(byte_rdata, exp_q.pop_front());
        if (kind[1]) chk(bit_rdata, exp_q.pop_front());
        if (kind[0]) chk(pop_data, exp_q.pop_front());
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h69446deb));
        repeat (10) @(posedge i_clk);
        #1;
        i_resetn = 1'b1;
        for (int i = 0; i < 10; i++) rd(4'h1, ra[i], rv[i]);
        strap = 2'h3;
        rd(4'h1, 8'hc0, 8'h06);
        chk(isp, 16'h0001);
        op(4'h0, 8'hc0, 16'h00fb);
        rd(4'h1, 8'hc0, 8'h06);
        code_addr = 16'hfc00;
        #1 chk(rom, 16'h0001);
        code_addr = 16'hfbff;
        #1 chk(rom, 16'h0000);
        op(4'h2, 8'hc1, 16'h0000);
        code_addr = 16'hffff;
        #1 chk(rom, 16'h0000);
        strap = 2'h1;
        rd(4'h1, 8'hc0, 8'h00);
        chk(isp, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            op(4'h0, 8'ha1, 16'(i));
            chk(bank, 16'(i % 2));
            rd(4'h1, 8'ha1, 8'(i % 2));
            op(4'h0, 8'hd0, 16'(i << 3));
            chk(work_bank, 16'(i));
            rd(4'h1, 8'hd0, 8'(i << 3));
        end
        op(4'h0, 8'hd0, 16'h00ff);
        op(4'h2, 8'hd5, 16'h0000);
        rd(4'h1, 8'hd0, 8'hde);
        op(4'h7, 8'h00, 16'h0003);
        rd(4'h1, 8'hd0, 8'h5e);
        op(4'h0, 8'hd0, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            a = 8'($urandom);
            y = 8'($urandom) | 8'h01;
            op(4'h4, 8'h00, {8'h00, a});
            rd(4'h3, 8'hd0, {7'h00, ^a});
            op(4'h0, 8'hf0, {8'h00, y});
            rd(4'h1, 8'hf0, y);
            op(4'h5, 8'h00, 16'h0000);
            prod = a * y;
            rd(4'h1, 8'he0, prod[7:0]);
            rd(4'h1, 8'hf0, prod[15:8]);
            rd(4'h3, 8'hd2, {7'h00, prod[15:8] != 8'h00});
            op(4'h0, 8'hf0, {8'h00, a});
            op(4'h0, 8'he0, {8'h00, y});
            op(4'h6, 8'h00, 16'h0000);
            rd(4'h1, 8'he0, a / y);
            rd(4'h1, 8'hf0, a % y);
        end
        for (int i = 0; i < 3; i++) begin
            stk[i] = 8'($urandom);
            op(4'h8, 8'h00, {8'h00, stk[i]});
        end
        rd(4'h1, 8'h81, 8'h0a);
        for (int i = 2; i >= 0; i--) rd(4'h9, 8'h00, stk[i]);
        rd(4'h1, 8'h81, 8'h07);
        op(4'h0, 8'h81, 16'h007e);
        op(4'h8, 8'h00, 16'h00a5);
        rd(4'h1, 8'h81, 8'h7f);
        rd(4'h9, 8'h00, 8'ha5);
        op(4'h8, 8'h00, 16'h003c);
        rd(4'h9, 8'h00, 8'h3c);
        op(4'ha, 8'h00, 16'h1234);
        chk(ptr_val, 16'h1234);
        op(4'h0, 8'ha2, 16'h0001);
        chk(ptr_val, 16'h0000);
        op(4'h0, 8'h82, 16'h00cd);
        op(4'h0, 8'h83, 16'h00ab);
        chk(ptr_val, 16'habcd);
        op(4'h0, 8'ha2, 16'h00fe);
        op(4'hb, 8'h00, 16'h0000);
        chk(ptr_val, 16'h1235);
        rd(4'h1, 8'h82, 8'h35);
        rd(4'h1, 8'ha2, 8'h00);
        repeat (3) @(posedge i_clk);
        results();
    end
endmodule : testbench
`default_nettype wire
